// ==== verilog/cerb_ram.sv ====
`timescale 1ns/1ps
// Operation
// - Port inputs captured in input registers, except clear, the flow-through read address and the shift-mode data and enable
// - True dual-port accepts any two operations
// - Same-address mixed read: old data or don't-care
// - Single-port write data appears on read output
// - Two half-size single-port memories share block
// - Ports may use different data widths
// - Block times its own write strobe
// - Output registers usable or bypassed
// - Simple dual-port flow-through read path
// - One parity bit stored per byte
// - Disabled byte lane keeps old contents
// - Shift size within 4608 bits
// - Shift tap width below 36
// - Shift data advances one stage per cycle
// - Last tap output feeds next block
// - Parallel blocks share address and control
// - No 36-bit width in true dual-port
// - 4608 storage bits, shapes 4096x1 to 128x36
module cerb_ram
    import cerb_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [REG_A_W-1:0] reg_addr_in,
    input wire logic [REG_D_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [REG_D_W-1:0] reg_rdata_out,
    input wire logic ce_a_in,
    input wire logic [ADDR_W-1:0] addr_a_in,
    input wire logic [WORD_W-1:0] wd_a_in,
    input wire logic [LANES-1:0] be_a_in,
    input wire logic we_a_in,
    input wire logic re_a_in,
    input wire logic clr_a_in,
    output logic [WORD_W-1:0] q_a_out,
    input wire logic ce_b_in,
    input wire logic [ADDR_W-1:0] addr_b_in,
    input wire logic [WORD_W-1:0] wd_b_in,
    input wire logic [LANES-1:0] be_b_in,
    input wire logic we_b_in,
    input wire logic re_b_in,
    input wire logic clr_b_in,
    output logic [WORD_W-1:0] q_b_out,
    output logic [WORD_W-1:0] sr_last_out
);

    // --------------------------------------------------------------
    // Port bundling
    // --------------------------------------------------------------
    logic [1:0] ce;
    logic [1:0] we_in;
    logic [1:0] re_in;
    logic [1:0] clr;
    logic [1:0][ADDR_W-1:0] addr_in;
    logic [1:0][WORD_W-1:0] wd_in;
    logic [1:0][LANES-1:0] be_in;

    assign ce = {ce_b_in, ce_a_in};
    assign we_in = {we_b_in, we_a_in};
    assign re_in = {re_b_in, re_a_in};
    assign clr = {clr_b_in, clr_a_in};
    assign addr_in = {addr_b_in, addr_a_in};
    assign wd_in = {wd_b_in, wd_a_in};
    assign be_in = {be_b_in, be_a_in};

    cerb_state_s st_ff;
    cerb_state_s nxt_st;

    // --------------------------------------------------------------
    // Configuration decode and legality
    // --------------------------------------------------------------
    logic [2:0] mode;
    logic [1:0][2:0] wcode;
    logic [1:0] oreg;
    logic rdw_old;
    logic flow;
    logic [ROW_W-1:0] sr_len;
    int sr_m;
    int sr_n;
    int sr_w;
    int sr_row_w;
    logic tdp_wide;
    logic sr_bits_err;
    logic sr_width_err;
    logic sr_err;
    logic shift_go;

    assign mode = st_ff.cfg[CFG_MODE_LSB +: 3];
    assign wcode[0] = st_ff.cfg[CFG_WA_LSB +: 3];
    assign wcode[1] = st_ff.cfg[CFG_WB_LSB +: 3];
    assign oreg = {st_ff.cfg[CFG_OREG_B], st_ff.cfg[CFG_OREG_A]};
    assign rdw_old = st_ff.cfg[CFG_RDW_OLD];
    assign flow = st_ff.cfg[CFG_FLOW];
    assign sr_len = st_ff.cfg[CFG_LEN_LSB +: ROW_W];
    assign sr_m = int'(sr_len) + 1;
    assign sr_n = int'(st_ff.cfg[CFG_TAPS_LSB +: 3]) + 1;
    assign sr_w = cerb_width_bits(wcode[0]);
    assign sr_row_w = sr_n * sr_w;
    assign tdp_wide = (mode == MODE_TDP) && (wcode[0] == W36 || wcode[1] == W36);
    assign sr_bits_err = (sr_m * sr_row_w) > CAP_BITS;
    assign sr_width_err = sr_row_w >= MAX_PORT_W;
    assign sr_err = sr_bits_err || sr_width_err;
    assign shift_go = (mode == MODE_SHIFT) && ce[0] && !sr_err;

    // --------------------------------------------------------------
    // Port roles per mode
    // --------------------------------------------------------------
    logic [1:0] wr_ok;
    logic [1:0] rd_ok;

    always_comb begin
        wr_ok = 2'h0;
        rd_ok = 2'h0;
        case (mode)
            MODE_TDP: begin
                wr_ok = {2{!tdp_wide}};
                rd_ok = 2'h3;
            end
            MODE_SDP: begin
                wr_ok = 2'h1;
                rd_ok = 2'h2;
            end
            MODE_SP: begin
                wr_ok = 2'h1;
                rd_ok = 2'h1;
            end
            MODE_DSP: begin
                wr_ok = 2'h3;
                rd_ok = 2'h3;
            end
            default: begin
                wr_ok = 2'h0;
                rd_ok = 2'h0;
            end
        endcase
    end

    // --------------------------------------------------------------
    // Per-port address mapping and read data
    // --------------------------------------------------------------
    logic [WORD_W-1:0] ones;
    logic [1:0] fthru;
    logic [1:0] wstb;
    logic [1:0] collide;
    logic [1:0][ADDR_W-1:0] map_addr;
    logic [1:0][ROW_W-1:0] map_row;
    logic [1:0][ROW_W-1:0] row_eff;
    logic [1:0][WORD_W-1:0] map_mask;
    logic [1:0][WORD_W-1:0] map_bits;
    logic [1:0][WORD_W-1:0] map_rd;
    logic [1:0][WORD_W-1:0] arr_rd;
    logic [1:0][WORD_W-1:0] wmask;
    logic [1:0][WORD_W-1:0] q_raw;
    logic [1:0][WORD_W-1:0] q_mux;

    assign ones = '1;

    for (genvar p = 0; p < 2; p++) begin : g_port
        // Read address taken straight from the port, no output register
        assign fthru[p] = (p == 1) && flow && (mode == MODE_SDP);
        assign map_addr[p] = fthru[p] ? addr_in[p] : st_ff.port[p].addr;
        // Each port has its own width code
        cerb_lane_map u_map (
            .width_in(wcode[p]),
            .addr_in(map_addr[p]),
            .wd_in(st_ff.port[p].wd),
            .be_in(st_ff.port[p].be),
            .row_data_in(arr_rd[p]),
            .row_out(map_row[p]),
            .mask_out(map_mask[p]),
            .bits_out(map_bits[p]),
            .rd_out(map_rd[p])
        );
        // Split block: port A lower half, port B upper half
        assign row_eff[p] = (mode == MODE_DSP) ? {(p == 1), map_row[p][ROW_W-2:0]} : map_row[p];
        // One strobe per captured write, from the port clock
        assign wstb[p] = st_ff.port[p].we && st_ff.port[p].fresh && wr_ok[p];
        assign wmask[p] = ones >> (WORD_W - cerb_width_bits(wcode[p]));
        assign collide[p] = (p == 1) && (mode == MODE_SDP) && !rdw_old && wstb[0]
            && (row_eff[0] == row_eff[1]);
        // Don't-care read on collision returns all ones
        assign q_raw[p] = collide[p] ? ones :
            (wstb[p] ? (st_ff.port[p].wd & wmask[p]) : map_rd[p]);
        assign q_mux[p] = (oreg[p] && !fthru[p]) ? st_ff.port[p].q : q_raw[p];
    end

    // --------------------------------------------------------------
    // Storage array
    // --------------------------------------------------------------
    logic [WORD_W-1:0] sr_wmask;
    logic [WORD_W-1:0] sr_rmask;
    logic [WORD_W-1:0] sr_next;

    assign sr_wmask = ones >> (WORD_W - sr_w);
    assign sr_rmask = ones >> (WORD_W - sr_row_w);
    // Old row read, shifted by one stage, rewritten same edge
    assign sr_next = ((arr_rd[0] << sr_w) | (wd_in[0] & sr_wmask)) & sr_rmask;

    // Parity bits stored as ordinary lane bits
    cerb_ram_array u_array (
        .clk_in(clk_in),
        .we_a_in(shift_go || wstb[0]),
        .row_a_in((mode == MODE_SHIFT) ? st_ff.ptr : row_eff[0]),
        .mask_a_in((mode == MODE_SHIFT) ? ones : map_mask[0]),
        .bits_a_in((mode == MODE_SHIFT) ? sr_next : map_bits[0]),
        .we_b_in(wstb[1]),
        .row_b_in(row_eff[1]),
        .mask_b_in(map_mask[1]),
        .bits_b_in(map_bits[1]),
        .rrow_a_in((mode == MODE_SHIFT) ? st_ff.ptr : row_eff[0]),
        .rrow_b_in(row_eff[1]),
        .rd_a_out(arr_rd[0]),
        .rd_b_out(arr_rd[1])
    );

    // --------------------------------------------------------------
    // Status word
    // --------------------------------------------------------------
    logic [REG_D_W-1:0] status;

    always_comb begin
        status = '0;
        status[STAT_TDP_WIDE] = tdp_wide;
        status[STAT_SR_BITS] = sr_bits_err;
        status[STAT_SR_WIDTH] = sr_width_err;
        status[STAT_PTR_LSB +: ROW_W] = st_ff.ptr;
    end

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = '0;
        if (reg_wr_in && reg_addr_in == REG_CFG) begin
            nxt_st.cfg = reg_wdata_in;
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_CFG: nxt_st.rdata = st_ff.cfg;
                REG_STAT: nxt_st.rdata = status;
                default: nxt_st.rdata = '0;
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            nxt_st.port[i].fresh = ce[i];
            if (ce[i]) begin
                nxt_st.port[i].addr = addr_in[i];
                nxt_st.port[i].wd = wd_in[i];
                nxt_st.port[i].be = be_in[i];
                nxt_st.port[i].we = we_in[i];
                nxt_st.port[i].re = re_in[i];
            end
            if (clr[i]) begin
                nxt_st.port[i].q = '0;
            end else if (st_ff.port[i].fresh && ((st_ff.port[i].re && rd_ok[i]) || wstb[i])) begin
                nxt_st.port[i].q = q_raw[i];
            end
        end
        if (mode != MODE_SHIFT) begin
            nxt_st.ptr = '0;
        end else if (shift_go) begin
            nxt_st.ptr = (st_ff.ptr == sr_len) ? '0 : st_ff.ptr + 7'h1;
            nxt_st.tap = arr_rd[0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_ff <= '0;
            st_ff.cfg <= CFG_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign reg_rdata_out = st_ff.rdata;
    assign q_a_out = (mode == MODE_SHIFT) ? st_ff.tap : q_mux[0];
    assign q_b_out = q_mux[1];
    // Cascade point into the next block's shift input
    assign sr_last_out = (st_ff.tap >> ((sr_n - 1) * sr_w)) & sr_wmask;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_sp_write;
        mode == MODE_SP && wcode[0] == W36 && ce[0] && we_in[0] && !clr[0];
    endsequence

    sequence s_quiet_a;
        !ce[0] && !clr[0];
    endsequence

    property p_in_reg;
        (ce[0] && we_in[0] && mode == MODE_SP) |=> wstb[0] && st_ff.port[0].addr == $past(addr_a_in);
    endproperty
    a_in_reg: assert property (p_in_reg) else $error("write not captured at port edge");

    property p_stb_once;
        (wstb[0] && !ce[0]) |=> !wstb[0];
    endproperty
    a_stb_once: assert property (p_stb_once) else $error("write strobe longer than one cycle");

    property p_sp_thru;
        (s_sp_write and !oreg[0]) |=> q_a_out == $past(wd_a_in);
    endproperty
    a_sp_thru: assert property (p_sp_thru) else $error("write data not on unregistered output");

    property p_sp_reg;
        (s_sp_write and oreg[0]) ##1 s_quiet_a |=> q_a_out == $past(wd_a_in, 2);
    endproperty
    a_sp_reg: assert property (p_sp_reg) else $error("write data not on registered output");

    property p_clr;
        (clr[0] && oreg[0] && mode != MODE_SHIFT) |=> q_a_out == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("output clear did not zero output");

    property p_tdp_wide;
        (mode == MODE_TDP && wcode[1] == W36 && ce[1] && we_in[1]) |=> !wstb[1] && status[STAT_TDP_WIDE];
    endproperty
    a_tdp_wide: assert property (p_tdp_wide) else $error("wide write accepted in true dual-port");

    property p_shift_step;
        shift_go |=> st_ff.ptr == (($past(st_ff.ptr) == sr_len) ? 7'h0 : $past(st_ff.ptr) + 7'h1);
    endproperty
    a_shift_step: assert property (p_shift_step) else $error("shift pointer did not advance one stage");

    property p_shift_bad;
        (mode == MODE_SHIFT && ce[0] && sr_err) |=> $stable(st_ff.tap) && $stable(st_ff.ptr);
    endproperty
    a_shift_bad: assert property (p_shift_bad) else $error("illegal shift shape still shifted");

    property p_lane_keep;
        (wstb[0] && wcode[0] == W36 && !st_ff.port[0].be[1]) |-> map_mask[0][17:9] == 9'h000;
    endproperty
    a_lane_keep: assert property (p_lane_keep) else $error("disabled lane written");

    property p_rdw_old;
        (mode == MODE_SDP && rdw_old && wstb[0] && !oreg[1] && !fthru[1]) |-> q_b_out == map_rd[1];
    endproperty
    a_rdw_old: assert property (p_rdw_old) else $error("mixed read did not return old data");

endmodule

// ==== include/cerb_pkg.sv ====
package cerb_pkg;

    // --------------------------------------------------------------
    // Array geometry
    // --------------------------------------------------------------
    localparam int ROWS = 128;
    localparam int ROW_W = 7;
    localparam int WORD_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int LANE_DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int CAP_BITS = 4608;
    localparam int MAX_PORT_W = 36;

    // --------------------------------------------------------------
    // Register port map
    // --------------------------------------------------------------
    localparam int REG_A_W = 4;
    localparam int REG_D_W = 32;
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;

    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_WA_LSB = 3;
    localparam int CFG_WB_LSB = 6;
    localparam int CFG_OREG_A = 9;
    localparam int CFG_OREG_B = 10;
    localparam int CFG_RDW_OLD = 11;
    localparam int CFG_FLOW = 12;
    localparam int CFG_LEN_LSB = 13;
    localparam int CFG_TAPS_LSB = 20;
    localparam logic [31:0] CFG_RESET = 32'h0000_0600;

    localparam int STAT_TDP_WIDE = 0;
    localparam int STAT_SR_BITS = 1;
    localparam int STAT_SR_WIDTH = 2;
    localparam int STAT_PTR_LSB = 8;

    // --------------------------------------------------------------
    // Modes and port widths
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_TDP = 3'h0,
        MODE_SDP = 3'h1,
        MODE_SP = 3'h2,
        MODE_DSP = 3'h3,
        MODE_SHIFT = 3'h4
    } cerb_mode_e;

    typedef enum logic [2:0] {
        W1 = 3'h0,
        W2 = 3'h1,
        W4 = 3'h2,
        W9 = 3'h3,
        W18 = 3'h4,
        W36 = 3'h5
    } cerb_width_e;

    function automatic int cerb_width_bits(input logic [2:0] code);
        case (code)
            W1: return 1;
            W2: return 2;
            W4: return 4;
            W9: return 9;
            W18: return 18;
            default: return 36;
        endcase
    endfunction

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wd;
        logic [LANES-1:0] be;
        logic we;
        logic re;
        logic fresh;
        logic [WORD_W-1:0] q;
    } cerb_port_s;

    typedef struct packed {
        logic [REG_D_W-1:0] cfg;
        logic [REG_D_W-1:0] rdata;
        cerb_port_s [1:0] port;
        logic [ROW_W-1:0] ptr;
        logic [WORD_W-1:0] tap;
    } cerb_state_s;

    typedef struct packed {
        logic [ROWS-1:0][WORD_W-1:0] mem;
    } cerb_arr_s;

endpackage

// ==== verilog/cerb_ram_array.sv ====
`timescale 1ns/1ps
module cerb_ram_array
    import cerb_pkg::*;
(
    input wire logic clk_in,
    input wire logic we_a_in,
    input wire logic [ROW_W-1:0] row_a_in,
    input wire logic [WORD_W-1:0] mask_a_in,
    input wire logic [WORD_W-1:0] bits_a_in,
    input wire logic we_b_in,
    input wire logic [ROW_W-1:0] row_b_in,
    input wire logic [WORD_W-1:0] mask_b_in,
    input wire logic [WORD_W-1:0] bits_b_in,
    input wire logic [ROW_W-1:0] rrow_a_in,
    input wire logic [ROW_W-1:0] rrow_b_in,
    output logic [WORD_W-1:0] rd_a_out,
    output logic [WORD_W-1:0] rd_b_out
);

    cerb_arr_s st_ff;
    cerb_arr_s nxt_st;

    // --------------------------------------------------------------
    // Masked row update, port A wins on shared bits
    // --------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (we_b_in) begin
            nxt_st.mem[row_b_in] = (st_ff.mem[row_b_in] & ~mask_b_in) | (bits_b_in & mask_b_in);
        end
        if (we_a_in) begin
            nxt_st.mem[row_a_in] = (nxt_st.mem[row_a_in] & ~mask_a_in) | (bits_a_in & mask_a_in);
        end
    end

    always_ff @(posedge clk_in) begin
        st_ff <= nxt_st;
    end

    // Reads see contents before this edge's write
    assign rd_a_out = st_ff.mem[rrow_a_in];
    assign rd_b_out = st_ff.mem[rrow_b_in];

endmodule

// ==== verilog/cerb_lane_map.sv ====
`timescale 1ns/1ps
module cerb_lane_map
    import cerb_pkg::*;
(
    input wire logic [2:0] width_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [WORD_W-1:0] wd_in,
    input wire logic [LANES-1:0] be_in,
    input wire logic [WORD_W-1:0] row_data_in,
    output logic [ROW_W-1:0] row_out,
    output logic [WORD_W-1:0] mask_out,
    output logic [WORD_W-1:0] bits_out,
    output logic [WORD_W-1:0] rd_out
);

    // --------------------------------------------------------------
    // Row select per port width
    // --------------------------------------------------------------
    always_comb begin
        case (width_in)
            W1: row_out = addr_in[11:5];
            W2: row_out = addr_in[10:4];
            W4: row_out = addr_in[9:3];
            W9: row_out = addr_in[8:2];
            W18: row_out = addr_in[7:1];
            default: row_out = addr_in[6:0];
        endcase
    end

    // --------------------------------------------------------------
    // Bit and lane placement inside the row
    // --------------------------------------------------------------
    always_comb begin
        int base;
        int nb;
        int nl;
        int pos;
        base = 0;
        nb = 0;
        nl = 0;
        pos = 0;
        rd_out = '0;
        mask_out = '0;
        bits_out = '0;
        case (width_in)
            W1: begin
                nb = 1;
                base = int'(addr_in[4:0]);
            end
            W2: begin
                nb = 2;
                base = int'({addr_in[3:0], 1'b0});
            end
            W4: begin
                nb = 4;
                base = int'({addr_in[2:0], 2'b00});
            end
            W9: begin
                nl = 1;
                base = int'(addr_in[1:0]);
            end
            W18: begin
                nl = 2;
                base = int'({addr_in[0], 1'b0});
            end
            default: begin
                nl = 4;
                base = 0;
            end
        endcase
        for (int i = 0; i < LANES; i++) begin
            // Narrow widths use data bits only, skipping parity
            if (i < nb) begin
                pos = ((base + i) / LANE_DATA_W) * LANE_W + (base + i) % LANE_DATA_W;
                rd_out[i] = row_data_in[pos];
                mask_out[pos] = 1'b1;
                bits_out[pos] = wd_in[i];
            end
            // Parity in bit 8 of each lane; enable covers all nine
            if (i < nl) begin
                rd_out[i*LANE_W +: LANE_W] = row_data_in[(base+i)*LANE_W +: LANE_W];
                mask_out[(base+i)*LANE_W +: LANE_W] = {LANE_W{be_in[i]}};
                bits_out[(base+i)*LANE_W +: LANE_W] = wd_in[i*LANE_W +: LANE_W];
            end
        end
    end

endmodule

// ==== sim/cerb_user_port.sv ====
`timescale 1ns/1ps
module cerb_user_port
    import cerb_pkg::*;
(
    input wire logic clk_in,
    output logic ce_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [WORD_W-1:0] wd_out,
    output logic [LANES-1:0] be_out,
    output logic we_out,
    output logic re_out,
    output logic clr_out
);
    // ----------------------------------------
    // One operation per call, set after an edge
    // ----------------------------------------
    initial begin
        {ce_out, addr_out, wd_out, be_out, we_out, re_out, clr_out} = '0;
    end

    task automatic drive(input logic ce, input logic w, input logic r, input logic [ADDR_W-1:0] a,
                         input logic [WORD_W-1:0] d, input logic [LANES-1:0] b, input logic c);
        @(posedge clk_in);
        ce_out <= ce;
        we_out <= w;
        re_out <= r & ~w;
        addr_out <= a;
        wd_out <= ce ? d : ~wd_out;
        be_out <= b;
        clr_out <= c;
    endtask
endmodule

// ==== sim/tb_cerb_ram.sv ====
`timescale 1ns/1ps
module tb_cerb_ram
    import cerb_pkg::*;
;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [REG_A_W-1:0] reg_addr_in = '0;
    logic [REG_D_W-1:0] reg_wdata_in = '0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [REG_D_W-1:0] reg_rdata_out;
    logic ce_a, we_a, re_a, clr_a, ce_b, we_b, re_b, clr_b;
    logic [ADDR_W-1:0] addr_a, addr_b;
    logic [WORD_W-1:0] wd_a, wd_b, q_a_out, q_b_out, sr_last_out;
    logic [LANES-1:0] be_a, be_b;
    int mismatches = 0;
    int n_compared = 0;

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end

    cerb_ram cerb_ram_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .ce_a_in(ce_a), .addr_a_in(addr_a), .wd_a_in(wd_a),
        .be_a_in(be_a), .we_a_in(we_a), .re_a_in(re_a), .clr_a_in(clr_a), .q_a_out(q_a_out),
        .ce_b_in(ce_b), .addr_b_in(addr_b), .wd_b_in(wd_b), .be_b_in(be_b), .we_b_in(we_b),
        .re_b_in(re_b), .clr_b_in(clr_b), .q_b_out(q_b_out), .sr_last_out(sr_last_out));
    cerb_user_port ua (.clk_in(clk_in), .ce_out(ce_a), .addr_out(addr_a), .wd_out(wd_a),
        .be_out(be_a), .we_out(we_a), .re_out(re_a), .clr_out(clr_a));
    cerb_user_port ub (.clk_in(clk_in), .ce_out(ce_b), .addr_out(addr_b), .wd_out(wd_b),
        .be_out(be_b), .we_out(we_b), .re_out(re_b), .clr_out(clr_b));

    // ----------------------------------------
    // Bus and port tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] cfg_of(input logic [2:0] m, input logic [2:0] wa, input logic [2:0] wb,
                                           input logic [1:0] o);
        return 32'(m) | (32'(wa) << CFG_WA_LSB) | (32'(wb) << CFG_WB_LSB) | (32'(o) << CFG_OREG_A);
    endfunction

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic reg_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 check({4'h0, reg_rdata_out}, {4'h0, e});
    endtask

    task automatic idle();
        fork
            ua.drive('0, '0, '0, '0, '0, '0, '0);
            ub.drive('0, '0, '0, '0, '0, '0, '0);
        join
    endtask

    task automatic rd(input logic b, input logic [11:0] a, input logic [35:0] e, input logic oreg);
        if (b) ub.drive('1, '0, '1, a, '0, '0, '0);
        else ua.drive('1, '0, '1, a, '0, '0, '0);
        idle();
        if (oreg) @(posedge clk_in);
        #1 check(b ? q_b_out : q_a_out, e);
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        stop_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        reg_chk(REG_CFG, CFG_RESET);
        reg_chk(REG_STAT, 32'h0);
        reg_chk(4'h8, 32'h0);
        $display("test reset done");
        reg_wr(REG_CFG, cfg_of(MODE_SP, W36, W36, 2'h3));
        ua.drive('1, '1, '0, 12'h005, 36'h923456789, 4'hf, '0);
        ua.drive('1, '1, '0, 12'h005, 36'h0, 4'h5, '0);
        idle();
        rd('0, 12'h005, 36'h920016600, '1);
        $display("test byte lanes done");
        reg_wr(REG_CFG, cfg_of(MODE_SP, W36, W36, 2'h2));
        ua.drive('1, '1, '0, 12'h006, 36'h5c3a1e7b2, 4'hf, '0);
        idle();
        #1 check(q_a_out, 36'h5c3a1e7b2);
        reg_wr(REG_CFG, cfg_of(MODE_SP, W36, W36, 2'h3));
        rd('0, 12'h006, 36'h5c3a1e7b2, '1);
        ua.drive('0, '0, '0, '0, '0, '0, '1);
        idle();
        #1 check(q_a_out, 36'h0);
        $display("test output paths done");
        ua.drive('1, '1, '0, 12'h003, 36'h0, 4'hf, '0);
        idle();
        reg_wr(REG_CFG, cfg_of(MODE_SDP, W1, W36, 2'h3));
        ua.drive('1, '1, '0, 12'd105, 36'h1, 4'hf, '0);
        idle();
        rd('1, 12'h003, 36'h400, '1);
        reg_wr(REG_CFG, cfg_of(MODE_SDP, W36, W36, 2'h3));
        fork
            ua.drive('1, '1, '0, 12'h003, 36'h5, 4'hf, '0);
            ub.drive('1, '0, '1, 12'h003, '0, '0, '0);
        join
        idle();
        @(posedge clk_in);
        #1 check(q_b_out, 36'hfffffffff);
        reg_wr(REG_CFG, cfg_of(MODE_SDP, W36, W36, 2'h1) | (32'h1 << CFG_RDW_OLD));
        fork
            ua.drive('1, '1, '0, 12'h003, 36'h6, 4'hf, '0);
            ub.drive('1, '0, '1, 12'h003, '0, '0, '0);
        join
        idle();
        #1 check(q_b_out, 36'h5);
        reg_wr(REG_CFG, cfg_of(MODE_SDP, W36, W36, 2'h3) | (32'h1 << CFG_FLOW));
        ub.drive('1, '0, '1, 12'h003, '0, '0, '0);
        #1 check(q_b_out, 36'h6);
        idle();
        $display("test mixed width done");
        reg_wr(REG_CFG, cfg_of(MODE_TDP, W18, W18, 2'h3));
        fork
            ua.drive('1, '1, '0, 12'h000, 36'h12345, 4'h3, '0);
            ub.drive('1, '1, '0, 12'h001, 36'h2abcd, 4'h3, '0);
        join
        fork
            ua.drive('1, '0, '1, 12'h001, '0, '0, '0);
            ub.drive('1, '0, '1, 12'h000, '0, '0, '0);
        join
        idle();
        @(posedge clk_in);
        #1 check(q_a_out, 36'h2abcd);
        check(q_b_out, 36'h12345);
        reg_wr(REG_CFG, cfg_of(MODE_TDP, W18, W36, 2'h3));
        ub.drive('1, '1, '0, 12'h000, '1, 4'hf, '0);
        idle();
        reg_chk(REG_STAT, 32'h1);
        rd('0, 12'h000, 36'h12345, '1);
        reg_wr(REG_CFG, cfg_of(MODE_DSP, W36, W36, 2'h3));
        fork
            ua.drive('1, '1, '0, 12'h000, 36'h111, 4'hf, '0);
            ub.drive('1, '1, '0, 12'h000, 36'h222, 4'hf, '0);
        join
        idle();
        rd('0, 12'h000, 36'h111, '1);
        rd('1, 12'h000, 36'h222, '1);
        $display("test dual port done");
        reg_wr(REG_CFG, cfg_of(MODE_SHIFT, W4, W1, 2'h0) | (32'h3 << CFG_LEN_LSB));
        for (int i = 0; i < 12; i++) begin
            ua.drive('1, '0, '0, '0, 36'(i), '0, '0);
            if (i >= 5) begin
                #1 check(sr_last_out, 36'(i - 5));
            end
        end
        idle();
        reg_wr(REG_CFG, cfg_of(MODE_SHIFT, W36, W1, 2'h0));
        ua.drive('1, '0, '0, '0, 36'h7, '0, '0);
        idle();
        reg_chk(REG_STAT, 32'h4);
        $display("test shift done");
        stop_test();
    end
endmodule
